/* File: src/ebr_pkg.sv */
// Constants, carriers and helpers shared by the boot record interpreter
package ebr_pkg;

  // Record command patterns found in the second word of each record
  localparam logic [15:0] EBR_CMD_RUN   = 16'h9999;
  localparam logic [15:0] EBR_CMD_WAIT  = 16'h5555;
  localparam logic [15:0] EBR_CMD_JUMP  = 16'haaaa;
  localparam logic [15:0] EBR_CMD_WRITE = 16'h6666;

  // Byte addresses and steps in the EEPROM image, and entry counts
  localparam logic [15:0] EBR_REC_START = 16'h0008;
  localparam logic [15:0] EBR_WORD_STEP = 16'h0002;
  localparam logic [15:0] EBR_BYTE_STEP = 16'h0001;
  localparam logic [15:0] EBR_ONE_ENTRY = 16'h0001;
  localparam logic [15:0] EBR_NO_ENTRY  = 16'h0000;

  typedef enum logic [3:0] {
    ST_START,
    ST_CNT,
    ST_CMD,
    ST_ADDR,
    ST_DATA,
    ST_MASK,
    ST_OFS,
    ST_RD,
    ST_WR,
    ST_DONE,
    ST_ERR
  } ebr_state_t;

  // Register bus request carrier
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ebr_rb_req_t;

  // Whole state of the interpreter
  typedef struct packed {
    ebr_state_t  st;
    logic        pend;
    logic        rb_pend;
    logic        rb_we;
    logic [15:0] ptr;
    logic [15:0] cnt;
    logic [15:0] cmd;
    logic [15:0] radr;
    logic [15:0] rdat;
    logic [15:0] mask;
    logic [15:0] ofs;
    logic        run;
    logic        done;
    logic        err;
  } ebr_ctl_t;

  // Whole state of the word fetcher
  typedef struct packed {
    logic        busy;
    logic        low;
    logic [15:0] addr;
    logic [7:0]  hi;
    logic [15:0] word;
    logic        valid;
  } ebr_fetch_t;

  localparam ebr_ctl_t   EBR_CTL_RST   = '0;
  localparam ebr_fetch_t EBR_FETCH_RST = '0;

  // Bits with mask 1 take part in the compare
  function automatic logic ebr_match(input logic [15:0] rd, input logic [15:0] exp,
                                     input logic [15:0] mask);
    ebr_match = ((rd ^ exp) & mask) == 16'h0000;
  endfunction

  // Only bits with enable 1 take the new value
  function automatic logic [15:0] ebr_merge(input logic [15:0] rd, input logic [15:0] nw,
                                            input logic [15:0] en);
    ebr_merge = (rd & ~en) | (nw & en);
  endfunction

  // Low byte of the offset sits one byte before ptr; offset counts words, signed
  function automatic logic [15:0] ebr_jump(input logic [15:0] ptr, input logic [15:0] ofs);
    ebr_jump = ptr - EBR_BYTE_STEP + {ofs[14:0], 1'b0};
  endfunction

endpackage

/* File: src/ebr_word_fetch.sv */
// Reads one 16-bit word, high byte first, from two consecutive EEPROM bytes
`timescale 1ns/100ps
module ebr_word_fetch (
  input  wire logic        sys_clk,     // System clock
  input  wire logic        rst,         // Synchronous reset
  input  wire logic        start,       // Begin a word read
  input  wire logic [15:0] start_addr,  // Byte address of the high byte
  output logic             word_valid,  // Word ready, one cycle
  output logic      [15:0] word,        // Fetched word
  output logic             ee_rd_req,   // Byte read request, held
  output logic      [15:0] ee_addr,     // Byte address to read
  input  wire logic        ee_rd_ack,   // Byte returned, one cycle
  input  wire logic [7:0]  ee_rd_data   // Returned byte
);

  ebr_pkg::ebr_fetch_t q, d;

  always_comb begin
    d = q;
    d.valid = 1'b0;
    if (!q.busy) begin
      if (start) begin
        d.busy = 1'b1;
        d.low  = 1'b0;
        d.addr = start_addr;
      end
    end else if (ee_rd_ack) begin
      if (!q.low) begin
        d.hi   = ee_rd_data;
        d.low  = 1'b1;
        d.addr = q.addr + ebr_pkg::EBR_BYTE_STEP;
      end else begin
        d.word  = {q.hi, ee_rd_data};
        d.valid = 1'b1;
        d.busy  = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= ebr_pkg::EBR_FETCH_RST;
    end else begin
      q <= d;
    end
  end

  assign ee_rd_req  = q.busy;
  assign ee_addr    = q.addr;
  assign word       = q.word;
  assign word_valid = q.valid;

endmodule // ebr_word_fetch

/* File: src/ebr_boot_interp.sv */
// Boot record interpreter: walks EEPROM records and drives the register bus
`timescale 1ns/100ps
module ebr_boot_interp (
  input  wire logic               sys_clk,     // System clock
  input  wire logic               rst,         // Synchronous reset
  output logic                    ee_rd_req,   // EEPROM byte read request
  output logic             [15:0] ee_addr,     // EEPROM byte address
  input  wire logic               ee_rd_ack,   // EEPROM byte returned
  input  wire logic        [7:0]  ee_rd_data,  // EEPROM byte data
  output logic                    rb_valid,    // Register access request, held
  output ebr_pkg::ebr_rb_req_t    rb_cmd,      // Write flag, address, write data
  input  wire logic               rb_ack,      // Access complete, one cycle
  input  wire logic        [15:0] rb_rdata,    // Read data with rb_ack
  output logic                    run_start,   // Self-start pulse
  output logic                    boot_done,   // Loading finished
  output logic                    boot_err     // Bad record met
);

  ebr_pkg::ebr_ctl_t q, d;
  logic              wf_start;
  logic              wf_valid;
  logic [15:0]       wf_word;

  ebr_word_fetch u_ebr_word_fetch (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .start      (wf_start),
    .start_addr (q.ptr),
    .word_valid (wf_valid),
    .word       (wf_word),
    .ee_rd_req  (ee_rd_req),
    .ee_addr    (ee_addr),
    .ee_rd_ack  (ee_rd_ack),
    .ee_rd_data (ee_rd_data)
  );

  always_comb begin
    d        = q;
    d.run    = 1'b0;
    wf_start = 1'b0;
    case (q.st)
      ebr_pkg::ST_START: begin
        d.ptr = ebr_pkg::EBR_REC_START;
        d.st  = ebr_pkg::ST_CNT;
      end
      ebr_pkg::ST_CNT, ebr_pkg::ST_CMD, ebr_pkg::ST_ADDR,
      ebr_pkg::ST_DATA, ebr_pkg::ST_MASK, ebr_pkg::ST_OFS: begin
        if (!q.pend) begin
          wf_start = 1'b1;
          d.pend   = 1'b1;
        end else if (wf_valid) begin
          d.pend = 1'b0;
          d.ptr  = q.ptr + ebr_pkg::EBR_WORD_STEP;
          case (q.st)
            ebr_pkg::ST_CNT: begin
              d.cnt = wf_word;
              d.st  = ebr_pkg::ST_CMD;
            end
            ebr_pkg::ST_CMD: begin
              d.cmd = wf_word;
              if (q.cnt == ebr_pkg::EBR_NO_ENTRY) begin
                d.st  = ebr_pkg::ST_ERR;
                d.err = 1'b1;
              end else begin
                case (wf_word)
                  ebr_pkg::EBR_CMD_RUN: begin
                    d.st   = ebr_pkg::ST_DONE;
                    d.run  = 1'b1;
                    d.done = 1'b1;
                  end
                  ebr_pkg::EBR_CMD_WAIT, ebr_pkg::EBR_CMD_JUMP,
                  ebr_pkg::EBR_CMD_WRITE: begin
                    d.st = ebr_pkg::ST_ADDR;
                  end
                  default: begin
                    d.st  = ebr_pkg::ST_ERR;
                    d.err = 1'b1;
                  end
                endcase
              end
            end
            ebr_pkg::ST_ADDR: begin
              d.radr = wf_word;
              d.st   = ebr_pkg::ST_DATA;
            end
            ebr_pkg::ST_DATA: begin
              d.rdat = wf_word;
              d.st   = ebr_pkg::ST_MASK;
            end
            ebr_pkg::ST_MASK: begin
              // Write records carry their bit enables in this slot
              d.mask = wf_word;
              d.st   = (q.cmd == ebr_pkg::EBR_CMD_JUMP) ? ebr_pkg::ST_OFS
                                                        : ebr_pkg::ST_RD;
            end
            default: begin
              d.ofs = wf_word;
              d.st  = ebr_pkg::ST_RD;
            end
          endcase
        end
      end
      ebr_pkg::ST_RD: begin
        if (!q.rb_pend) begin
          d.rb_pend = 1'b1;
          d.rb_we   = 1'b0;
        end else if (rb_ack) begin
          d.rb_pend = 1'b0;
          case (q.cmd)
            ebr_pkg::EBR_CMD_WAIT: begin
              // No timeout: a register that never matches holds boot here
              if (ebr_pkg::ebr_match(rb_rdata, q.rdat, q.mask)) begin
                d.st = ebr_pkg::ST_CNT;
              end
            end
            ebr_pkg::EBR_CMD_JUMP: begin
              if (ebr_pkg::ebr_match(rb_rdata, q.rdat, q.mask)) begin
                d.ptr = ebr_pkg::ebr_jump(q.ptr, q.ofs);
              end
              d.st = ebr_pkg::ST_CNT;
            end
            default: begin
              d.rdat = ebr_pkg::ebr_merge(rb_rdata, q.rdat, q.mask);
              d.st   = ebr_pkg::ST_WR;
            end
          endcase
        end
      end
      ebr_pkg::ST_WR: begin
        if (!q.rb_pend) begin
          d.rb_pend = 1'b1;
          d.rb_we   = 1'b1;
        end else if (rb_ack) begin
          d.rb_pend = 1'b0;
          d.cnt     = q.cnt - ebr_pkg::EBR_ONE_ENTRY;
          d.st      = (q.cnt == ebr_pkg::EBR_ONE_ENTRY) ? ebr_pkg::ST_CNT
                                                        : ebr_pkg::ST_ADDR;
        end
      end
      ebr_pkg::ST_DONE, ebr_pkg::ST_ERR: begin
        d.st = q.st;
      end
      default: begin
        d.st  = ebr_pkg::ST_ERR;
        d.err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= ebr_pkg::EBR_CTL_RST;
    end else begin
      q <= d;
    end
  end

  assign rb_valid     = q.rb_pend;
  assign rb_cmd.we    = q.rb_we;
  assign rb_cmd.addr  = q.radr;
  assign rb_cmd.wdata = q.rdat;
  assign run_start    = q.run;
  assign boot_done    = q.done;
  assign boot_err     = q.err;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_word_step: assert property (wf_valid && q.pend |=> q.ptr == $past(q.ptr) + 16'h0002 ||
                                q.st == ebr_pkg::ST_ERR)
    else $error("Pointer did not advance by one word");
  a_rec_start: assert property (q.st == ebr_pkg::ST_START |=> q.ptr == 16'h0008 ##1
                                ee_addr == 16'h0008)
    else $error("First record not read from byte 8");
  a_run_start: assert property (q.st == ebr_pkg::ST_CMD && wf_valid && q.pend &&
                                wf_word == 16'h9999 && q.cnt != 16'h0000
                                |=> run_start && boot_done ##1 !run_start)
    else $error("Self-start record not honoured");
  a_zero_count: assert property (q.st == ebr_pkg::ST_CMD && wf_valid && q.pend &&
                                 q.cnt == 16'h0000 |=> boot_err && !boot_done)
    else $error("Zero entry count accepted");
  a_wait_decode: assert property (q.st == ebr_pkg::ST_CMD && wf_valid && q.pend &&
                                  wf_word == 16'h5555 && q.cnt != 16'h0000
                                  |=> q.st == ebr_pkg::ST_ADDR)
    else $error("Wait record not decoded");
  a_wait_poll: assert property (q.st == ebr_pkg::ST_RD && rb_ack && q.rb_pend &&
                                q.cmd == 16'h5555 &&
                                ((rb_rdata ^ q.rdat) & q.mask) != 16'h0000
                                |=> q.st == ebr_pkg::ST_RD ##1 rb_valid && !rb_cmd.we)
    else $error("Wait record did not poll again");
  a_jump_skip: assert property (q.st == ebr_pkg::ST_RD && rb_ack && q.rb_pend &&
                                q.cmd == 16'haaaa &&
                                ((rb_rdata ^ q.rdat) & q.mask) != 16'h0000
                                |=> $stable(q.ptr) && q.st == ebr_pkg::ST_CNT)
    else $error("Jump taken on mismatch");
  a_jump_dest: assert property (q.st == ebr_pkg::ST_RD && rb_ack && q.rb_pend &&
                                q.cmd == 16'haaaa &&
                                ((rb_rdata ^ q.rdat) & q.mask) == 16'h0000
                                |=> q.ptr == $past(q.ptr) - 16'h0001 +
                                    {$past(q.ofs[14:0]), 1'b0})
    else $error("Jump destination wrong");
  a_mask_ignore: assert property (q.st == ebr_pkg::ST_RD && rb_ack && q.rb_pend &&
                                  q.cmd == 16'h5555 && q.mask == 16'h0000
                                  |=> q.st == ebr_pkg::ST_CNT)
    else $error("Unmasked bits affected compare");
  a_rmw_data: assert property (q.st == ebr_pkg::ST_RD && rb_ack && q.rb_pend &&
                               q.cmd == 16'h6666
                               |=> ##1 rb_valid && rb_cmd.we && rb_cmd.wdata ==
                                   (($past(rb_rdata, 2) & ~q.mask) | ($past(q.rdat, 2) & q.mask)))
    else $error("Read-modify-write merged wrongly");

  c_boot_done: cover property (run_start);
  c_jump_back: cover property (q.st == ebr_pkg::ST_RD ##1 q.ptr < $past(q.ptr));
  c_poll_again: cover property (q.st == ebr_pkg::ST_RD && q.cmd == 16'h5555 && rb_ack ##1
                                q.st == ebr_pkg::ST_RD);
  c_multi_write: cover property (q.st == ebr_pkg::ST_WR && rb_ack && q.cnt > 16'h0001);

endmodule // ebr_boot_interp

/* File: sim/ebr_ee_model.sv */
// Behavioural EEPROM byte source facing the boot record interpreter
`timescale 1ns/100ps
module ebr_ee_model (
  input  wire logic        sys_clk,     // System clock
  input  wire logic        clr,         // Clears the lowest-address record
  input  wire logic        ee_rd_req,   // Byte read request
  input  wire logic [15:0] ee_addr,     // Byte address
  input  wire logic [3:0]  ack_dly,     // Idle cycles before each ack
  output logic             ee_rd_ack,   // Byte returned
  output logic      [7:0]  ee_rd_data,  // Byte data
  output logic      [15:0] low_addr     // Lowest address read so far
);
  logic [7:0] mem [0:255];
  logic [3:0] wait_n;
  initial begin
    ee_rd_ack  = 1'b0;
    ee_rd_data = 8'h00;
    wait_n     = 4'h0;
    low_addr   = 16'hffff;
  end
  // Released data line flips every cycle so a stale byte never looks valid
  always @(negedge sys_clk) begin
    if (clr) begin
      low_addr <= 16'hffff;
    end
    if (ee_rd_ack) begin
      ee_rd_ack  <= 1'b0;
      ee_rd_data <= ~ee_rd_data;
      wait_n     <= 4'h0;
    end else if (ee_rd_req && wait_n >= ack_dly) begin
      ee_rd_ack  <= 1'b1;
      ee_rd_data <= mem[ee_addr[7:0]];
      if (!clr && ee_addr < low_addr) begin
        low_addr <= ee_addr;
      end
    end else begin
      ee_rd_data <= ~ee_rd_data;
      if (ee_rd_req) begin
        wait_n <= wait_n + 4'h1;
      end
    end
  end
endmodule // ebr_ee_model

/* File: sim/ebr_boot_interp_tb.sv */
// Self-checking bench for the boot record interpreter
`timescale 1ns/100ps
module ebr_boot_interp_tb;
  logic                 sys_clk, rst, ee_clr, ee_rd_req, ee_rd_ack, rb_valid, rb_ack;
  logic                 run_start, boot_done, boot_err;
  logic [15:0]          ee_addr, rb_rdata, low_addr;
  logic [7:0]           ee_rd_data;
  logic [3:0]           ee_dly, rb_dly, rb_wait;
  ebr_pkg::ebr_rb_req_t rb_cmd;
  logic [15:0]          regs [0:15];
  int                   bad_count, tests_run, reads_n, writes_n, runs_n;

  ebr_boot_interp u_ebr_boot_interp (.sys_clk(sys_clk), .rst(rst), .ee_rd_req(ee_rd_req),
    .ee_addr(ee_addr), .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data), .rb_valid(rb_valid),
    .rb_cmd(rb_cmd), .rb_ack(rb_ack), .rb_rdata(rb_rdata), .run_start(run_start),
    .boot_done(boot_done), .boot_err(boot_err));
  ebr_ee_model u_ebr_ee_model (.sys_clk(sys_clk), .clr(ee_clr), .ee_rd_req(ee_rd_req),
    .ee_addr(ee_addr), .ack_dly(ee_dly), .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data),
    .low_addr(low_addr));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Register bus responder; register 3 settles on its third read
  always @(negedge sys_clk) begin
    if (rb_ack) begin
      rb_ack   <= 1'b0;
      rb_rdata <= ~rb_rdata;
      rb_wait  <= 4'h0;
    end else if (rb_valid && rb_wait >= rb_dly) begin
      rb_ack <= 1'b1;
      if (rb_cmd.we) begin
        regs[rb_cmd.addr[3:0]] <= rb_cmd.wdata;
        writes_n <= writes_n + 1;
      end else begin
        rb_rdata <= regs[rb_cmd.addr[3:0]];
        reads_n <= reads_n + 1;
        if (reads_n == 1) begin
          regs[3] <= 16'h34a5;
        end
      end
    end else begin
      rb_rdata <= ~rb_rdata;
      if (rb_valid) begin
        rb_wait <= rb_wait + 4'h1;
      end
    end
    if (run_start === 1'b1) begin
      runs_n <= runs_n + 1;
    end
  end

  task automatic report_and_stop();
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic put_w(input int a, input logic [15:0] w);
    u_ebr_ee_model.mem[a] = w[15:8];
    u_ebr_ee_model.mem[a+1] = w[7:0];
  endtask

  // Blank image decodes as ffff/ffff, an unknown command, so strays end in error
  task automatic begin_case(input logic [3:0] ed, input logic [3:0] rd);
    @(negedge sys_clk);
    rst    = 1'b1;
    ee_clr = 1'b1;
    ee_dly = ed;
    rb_dly = rd;
    for (int i = 0; i < 256; i++) u_ebr_ee_model.mem[i] = (i < 8) ? 8'h00 : 8'hff;
    for (int i = 0; i < 16; i++) regs[i] = 16'h0000;
    reads_n  = 0;
    writes_n = 0;
    runs_n   = 0;
    repeat (16) @(negedge sys_clk);
    rst    = 1'b0;
    ee_clr = 1'b0;
  endtask

  task automatic run_to_end(input logic err, input int rds, input int wrs, input string what);
    int n;
    n = 0;
    while (!(boot_done === 1'b1 || boot_err === 1'b1) && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (6) @(negedge sys_clk);
    chk({what, " done"}, {15'h0000, ~err}, {15'h0000, boot_done});
    chk({what, " err"}, {15'h0000, err}, {15'h0000, boot_err});
    chk({what, " starts"}, {15'h0000, ~err}, 16'(runs_n));
    chk({what, " halted"}, 16'h0000, {15'h0000, ee_rd_req | rb_valid});
    chk({what, " reads"}, 16'(rds), 16'(reads_n));
    chk({what, " writes"}, 16'(wrs), 16'(writes_n));
    chk({what, " first byte"}, ebr_pkg::EBR_REC_START, low_addr);
  endtask

  task automatic s_run();
    begin_case(4'h3, 4'h0);
    put_w(8, 16'h0100);
    put_w(10, ebr_pkg::EBR_CMD_RUN);
    run_to_end(1'b0, 0, 0, "run");
  endtask

  task automatic s_refused(input logic [15:0] cnt, input logic [15:0] cmd);
    begin_case(4'h1, 4'h1);
    put_w(8, cnt);
    put_w(10, cmd);
    run_to_end(1'b1, 0, 0, "refused");
  endtask

  task automatic s_wait();
    begin_case(4'h1, 4'h2);
    regs[3] = 16'h12a0;
    put_w(8, 16'h0001);
    put_w(10, ebr_pkg::EBR_CMD_WAIT);
    put_w(12, 16'h0003);
    put_w(14, 16'h00a5);
    put_w(16, 16'h00ff);
    // Second wait record has an all-zero mask, so it must match on its first read
    put_w(18, 16'h0001);
    put_w(20, ebr_pkg::EBR_CMD_WAIT);
    put_w(22, 16'h0004);
    put_w(24, 16'hffff);
    put_w(26, 16'h0000);
    put_w(28, 16'h0001);
    put_w(30, ebr_pkg::EBR_CMD_RUN);
    run_to_end(1'b0, 4, 0, "wait");
  endtask

  // Taken: 8 -> 0x41 forward, then 0x41 -> 0x22 backward; target 0x41 odd, 0x22 even
  task automatic s_jump(input logic take);
    begin_case(take ? 4'h0 : 4'h2, take ? 4'h1 : 4'h0);
    regs[2] = take ? 16'hff55 : 16'h0054;
    put_w(8, 16'h0001);
    put_w(10, ebr_pkg::EBR_CMD_JUMP);
    put_w(12, 16'h0002);
    put_w(14, 16'h0055);
    put_w(16, 16'h00ff);
    put_w(18, 16'h0017);
    put_w(8'h41, 16'h0001);
    put_w(8'h43, ebr_pkg::EBR_CMD_JUMP);
    put_w(8'h45, 16'h0002);
    put_w(8'h47, 16'h0055);
    put_w(8'h49, 16'h00ff);
    put_w(8'h4b, 16'hffeb);
    put_w(take ? 8'h22 : 8'h14, 16'h0001);
    put_w(take ? 8'h24 : 8'h16, ebr_pkg::EBR_CMD_RUN);
    run_to_end(1'b0, take ? 2 : 1, 0, "jump");
  endtask

  task automatic s_write();
    begin_case(4'h0, 4'h3);
    regs[5] = 16'h5555;
    put_w(8, 16'h0002);
    put_w(10, ebr_pkg::EBR_CMD_WRITE);
    put_w(12, 16'h0005);
    put_w(14, 16'habcd);
    put_w(16, 16'h0f0f);
    put_w(18, 16'h0006);
    put_w(20, 16'h1234);
    put_w(22, 16'hffff);
    put_w(24, 16'h0001);
    put_w(26, ebr_pkg::EBR_CMD_RUN);
    run_to_end(1'b0, 2, 2, "write");
    chk("merged reg 5", 16'h5b5d, regs[5]);
    chk("full reg 6", 16'h1234, regs[6]);
  endtask

  initial begin
    rst       = 1'b1;
    ee_clr    = 1'b1;
    ee_dly    = 4'h0;
    rb_dly    = 4'h0;
    rb_ack    = 1'b0;
    rb_rdata  = 16'h0000;
    rb_wait   = 4'h0;
    bad_count = 0;
    tests_run = 0;
    s_run();
    s_refused(16'h0000, ebr_pkg::EBR_CMD_RUN);
    s_refused(16'h0001, 16'h9998);
    s_wait();
    s_jump(1'b1);
    s_jump(1'b0);
    s_write();
    report_and_stop();
  end

  // Seven short scenarios need a few thousand cycles at most
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    report_and_stop();
  end
endmodule // ebr_boot_interp_tb
